// File: inc/ocs_pkg.sv
// Constants, register map and types of the oscillator clock source switch.
package ocs_pkg;

	// --------------------------------------------------------------------
	// Register map (byte addresses) and field positions
	// --------------------------------------------------------------------
	localparam logic [7:0] OFS_TRIM         = 8'h38;
	localparam logic [7:0] OFS_STATUS       = 8'h3c;
	localparam logic [7:0] OFS_CONFIG       = 8'h40;
	localparam logic [7:0] OFS_PULLUP       = 8'h44;
	localparam int         STATUS_REQ_BIT   = 0;
	localparam int         STATUS_ENG_BIT   = 1;
	localparam int         PULLUP_OSC_OUT_PIN_BIT  = 0;

	// --------------------------------------------------------------------
	// Reset values, counts and response codes
	// --------------------------------------------------------------------
	localparam logic [7:0] TRIM_RST         = 8'h80;
	localparam logic [8:0] INT_HALF_BASE    = 9'h001;
	localparam logic [1:0] EDGE_CHECK_COUNT = 2'h2;
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;

	// --------------------------------------------------------------------
	// Types
	// --------------------------------------------------------------------
	typedef enum logic [1:0]
	{
		SRC_INT  = 2'h0,
		SRC_EXT  = 2'h1,
		SRC_RC   = 2'h2,
		SRC_XTAL = 2'h3
	} ocs_src_e;

	typedef enum logic [1:0]
	{
		ST_INT   = 2'h0,
		ST_CHECK = 2'h1,
		ST_ARM   = 2'h3,
		ST_EXT   = 2'h2
	} ocs_state_e;

	typedef enum logic [1:0]
	{
		PIN1_RELEASED = 2'h0,
		PIN1_EXT_IN   = 2'h1,
		PIN1_RC_IN    = 2'h2,
		PIN1_XTAL_IN  = 2'h3
	} ocs_pin1_e;

	typedef struct packed
	{
		logic o;
		logic oe;
	} ocs_pad_s;

endpackage

// File: design/ocs_sync.sv
// Two-flop synchroniser for levels that arrive from outside the clock domain.
module ocs_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;

	// The first stage feeds only the second stage.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule

// File: design/ocs_edge_check.sv
// Counts rising edges of a synchronised clock level up to a fixed target.
module ocs_edge_check (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic clear,
	input  wire logic level,
	output logic      seen
);

	logic       prev_ff;
	logic [1:0] cnt_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			prev_ff <= 1'b0;
		else
			prev_ff <= level;
	end

	// Saturates at the target so a running clock cannot wrap it back.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
			cnt_ff <= 2'h0;
		else if (level && !prev_ff && cnt_ff != ocs_pkg::EDGE_CHECK_COUNT)
			cnt_ff <= cnt_ff + 2'h1;
	end

	assign seen = (cnt_ff == ocs_pkg::EDGE_CHECK_COUNT);

endmodule

// File: design/ocs_clock_switch.sv
// Oscillator source selection, glitch-free switch and pin control.
//
// The AXI4-Lite register port was decided locally.
module ocs_clock_switch (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              osc_in_pin,
	input  wire logic              osc_out_pin_in,
	input  wire logic              rc_osc_clock,
	input  wire logic              crystal_osc_clock,
	input  wire logic              stop_mode,
	input  wire ocs_pkg::ocs_pad_s porta_bit4_pad,
	output ocs_pkg::ocs_pad_s      osc_out_pad,
	output logic                   porta_bit4_in,
	output ocs_pkg::ocs_pin1_e     osc_in_role,
	output logic                   full_rate_clock,
	output logic                   half_rate_clock,
	output logic                   internal_osc_run,
	output logic                   ext_clock_engaged
);

	// --------------------------------------------------------------------
	// Synchronised pins
	// --------------------------------------------------------------------
	logic [3:0] pins_sync;
	logic       osc_in_lvl;
	logic       rc_lvl;
	logic       xtal_lvl;

	ocs_sync #(.W(4)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({osc_out_pin_in, crystal_osc_clock, rc_osc_clock,
			osc_in_pin}),
		.sync_out (pins_sync)
	);

	assign osc_in_lvl    = pins_sync[0];
	assign rc_lvl        = pins_sync[1];
	assign xtal_lvl      = pins_sync[2];
	assign porta_bit4_in = pins_sync[3];

	// --------------------------------------------------------------------
	// Register bus
	// --------------------------------------------------------------------
	logic [7:0]        trim_ff;
	logic              req_ff;
	ocs_pkg::ocs_src_e src_ff;
	logic              pin2_clock_out_enable_ff;
	logic              aw_hold_ff;
	logic              w_hold_ff;
	logic [7:0]        awaddr_ff;
	logic [7:0]        wbyte_ff;
	logic              wlane_ff;
	logic              do_write;
	logic              wr_hit;
	logic [31:0]       nxt_rdata;
	logic              rd_hit;
	ocs_pkg::ocs_state_e state_ff;

	assign awready  = !aw_hold_ff && !bvalid;
	assign wready   = !w_hold_ff && !bvalid;
	assign arready  = !rvalid;
	assign do_write = aw_hold_ff && w_hold_ff && !bvalid;
	assign wr_hit   = awaddr_ff == ocs_pkg::OFS_TRIM
		|| awaddr_ff == ocs_pkg::OFS_STATUS
		|| awaddr_ff == ocs_pkg::OFS_CONFIG
		|| awaddr_ff == ocs_pkg::OFS_PULLUP;

	// Address and data are held independently, so either may come first.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= 8'h00;
			wbyte_ff   <= 8'h00;
			wlane_ff   <= 1'b0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_hold_ff <= 1'b1;
				awaddr_ff  <= awaddr;
			end
			else if (do_write)
				aw_hold_ff <= 1'b0;
			if (wvalid && wready)
			begin
				w_hold_ff <= 1'b1;
				wbyte_ff  <= wdata[7:0];
				wlane_ff  <= wstrb[0];
			end
			else if (do_write)
				w_hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= ocs_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? ocs_pkg::RESP_OKAY : ocs_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			trim_ff <= ocs_pkg::TRIM_RST;
		else if (do_write && wlane_ff && awaddr_ff == ocs_pkg::OFS_TRIM)
			trim_ff <= wbyte_ff;
	end

	// Request bit forced low in reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			req_ff <= 1'b0;
		else if (do_write && wlane_ff && awaddr_ff == ocs_pkg::OFS_STATUS)
			req_ff <= wbyte_ff[ocs_pkg::STATUS_REQ_BIT];
	end

	// Source select is frozen once a switch has begun, since the check
	// and the mux must keep looking at the same source.
	// Reset picks internal
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_ff    <= ocs_pkg::SRC_INT;
			pin2_clock_out_enable_ff <= 1'b0;
		end
		else if (do_write && wlane_ff)
		begin
			if (awaddr_ff == ocs_pkg::OFS_CONFIG && state_ff == ocs_pkg::ST_INT)
				src_ff <= ocs_pkg::ocs_src_e'(wbyte_ff[1:0]);
			if (awaddr_ff == ocs_pkg::OFS_PULLUP)
				pin2_clock_out_enable_ff <= wbyte_ff[ocs_pkg::PULLUP_OSC_OUT_PIN_BIT];
		end
	end

	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		rd_hit    = 1'b1;
		unique case (araddr)
			ocs_pkg::OFS_TRIM:   nxt_rdata[7:0] = trim_ff;
			ocs_pkg::OFS_STATUS:
			begin
				nxt_rdata[ocs_pkg::STATUS_REQ_BIT] = req_ff;
				nxt_rdata[ocs_pkg::STATUS_ENG_BIT] = ext_clock_engaged;
			end
			ocs_pkg::OFS_CONFIG: nxt_rdata[1:0] = src_ff;
			ocs_pkg::OFS_PULLUP: nxt_rdata[ocs_pkg::PULLUP_OSC_OUT_PIN_BIT] = pin2_clock_out_enable_ff;
			default:             rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= ocs_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= nxt_rdata;
			rresp  <= rd_hit ? ocs_pkg::RESP_OKAY : ocs_pkg::RESP_SLVERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// --------------------------------------------------------------------
	// Internal oscillator
	// --------------------------------------------------------------------
	logic [8:0] int_cnt_ff;
	logic       int_lvl_ff;
	logic [8:0] int_half;

	assign int_half = ocs_pkg::INT_HALF_BASE + {1'b0, trim_ff};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_cnt_ff <= 9'h000;
			int_lvl_ff <= 1'b0;
		end
		else if (internal_osc_run && !stop_mode)
		begin
			if (int_cnt_ff >= int_half)
			begin
				int_cnt_ff <= 9'h000;
				int_lvl_ff <= !int_lvl_ff;
			end
			else
				int_cnt_ff <= int_cnt_ff + 9'h001;
		end
	end

	// --------------------------------------------------------------------
	// Switch sequence
	// --------------------------------------------------------------------
	logic ext_lvl;
	logic edges_seen;
	logic sel_ext_ff;

	always_comb
	begin
		unique case (src_ff)
			ocs_pkg::SRC_EXT:  ext_lvl = osc_in_lvl;
			ocs_pkg::SRC_RC:   ext_lvl = rc_lvl;
			ocs_pkg::SRC_XTAL: ext_lvl = xtal_lvl;
			ocs_pkg::SRC_INT:  ext_lvl = 1'b0;
		endcase
	end

	ocs_edge_check u_edges (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (state_ff != ocs_pkg::ST_CHECK),
		.level   (ext_lvl),
		.seen    (edges_seen)
	);

	// No way back out of external
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_ff <= ocs_pkg::ST_INT;
		else
			unique case (state_ff)
				ocs_pkg::ST_INT:
					if (req_ff && src_ff != ocs_pkg::SRC_INT)
						state_ff <= ocs_pkg::ST_CHECK;
				ocs_pkg::ST_CHECK:
					if (!req_ff)
						state_ff <= ocs_pkg::ST_INT;
					else if (edges_seen)
						state_ff <= ocs_pkg::ST_ARM;
				ocs_pkg::ST_ARM:
					if (!int_lvl_ff && !ext_lvl)
						state_ff <= ocs_pkg::ST_EXT;
				ocs_pkg::ST_EXT:
					state_ff <= ocs_pkg::ST_EXT;
			endcase
	end

	// Mux moves only with both low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sel_ext_ff <= 1'b0;
		else if (state_ff == ocs_pkg::ST_ARM && !int_lvl_ff && !ext_lvl)
			sel_ext_ff <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_clock_engaged <= 1'b0;
			internal_osc_run  <= 1'b1;
		end
		else
		begin
			if (sel_ext_ff)
				ext_clock_engaged <= 1'b1;
			if (ext_clock_engaged)
				internal_osc_run <= 1'b0;
		end
	end

	// --------------------------------------------------------------------
	// Output clocks
	// --------------------------------------------------------------------
	logic nxt_full;

	// Both inputs low at the change
	assign nxt_full = !stop_mode && (sel_ext_ff ? ext_lvl : int_lvl_ff);

	// Half rate toggles on full rate rise
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			full_rate_clock <= 1'b0;
			half_rate_clock <= 1'b0;
		end
		else
		begin
			full_rate_clock <= nxt_full;
			if (nxt_full && !full_rate_clock)
				half_rate_clock <= !half_rate_clock;
		end
	end

	// --------------------------------------------------------------------
	// Pin functions
	// --------------------------------------------------------------------
	// Pin one role per source
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			osc_in_role <= ocs_pkg::PIN1_RELEASED;
			osc_out_pad <= '0;
		end
		else
			unique case (src_ff)
				ocs_pkg::SRC_INT:
				begin
					osc_in_role <= ocs_pkg::PIN1_RELEASED;
					osc_out_pad <= pin2_clock_out_enable_ff
						? ocs_pkg::ocs_pad_s'{o: nxt_full, oe: 1'b1}
						: porta_bit4_pad;
				end
				ocs_pkg::SRC_RC:
				begin
					osc_in_role <= ocs_pkg::PIN1_RC_IN;
					osc_out_pad <= pin2_clock_out_enable_ff
						? ocs_pkg::ocs_pad_s'{o: nxt_full, oe: 1'b1}
						: porta_bit4_pad;
				end
				ocs_pkg::SRC_EXT:
				begin
					osc_in_role <= ocs_pkg::PIN1_EXT_IN;
					osc_out_pad <= porta_bit4_pad;
				end
				ocs_pkg::SRC_XTAL:
				begin
					osc_in_role <= ocs_pkg::PIN1_XTAL_IN;
					osc_out_pad <= '{o: !osc_in_lvl, oe: 1'b1};
				end
			endcase
	end

	// --------------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------------
	a_trim_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> trim_ff == 8'h80 && !req_ff)
		else $error("Trim or request not at reset value.");
	a_engage_order: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ext_clock_engaged) |-> internal_osc_run ##1 !internal_osc_run)
		else $error("Internal oscillator stopped out of order.");
	a_no_fallback: assert property (@(posedge aclk) disable iff (!aresetn)
		ext_clock_engaged |=> ext_clock_engaged && sel_ext_ff)
		else $error("Clock fell back to internal source.");
	a_switch_low: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(sel_ext_ff) |-> !$past(int_lvl_ff) && !$past(ext_lvl))
		else $error("Switch taken while a source was high.");
	a_two_edges: assert property (@(posedge aclk) disable iff (!aresetn)
		state_ff == ocs_pkg::ST_CHECK && !edges_seen
			|=> state_ff != ocs_pkg::ST_ARM && !sel_ext_ff)
		else $error("Switch armed before two edges.");
	a_half_rate: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(full_rate_clock) |-> half_rate_clock != $past(half_rate_clock))
		else $error("Half rate clock missed a toggle.");
	a_stop_halt: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_mode ##1 stop_mode |-> !full_rate_clock && $stable(half_rate_clock))
		else $error("Clocks ran during stop mode.");
	a_pin2_ext: assert property (@(posedge aclk) disable iff (!aresetn)
		src_ff == ocs_pkg::SRC_EXT |=> osc_out_pad == $past(porta_bit4_pad))
		else $error("Pin two not port bit in external mode.");
	a_pin2_clock: assert property (@(posedge aclk) disable iff (!aresetn)
		src_ff == ocs_pkg::SRC_RC && pin2_clock_out_enable_ff |=> osc_out_pad.oe
			&& osc_out_pad.o == full_rate_clock)
		else $error("Pin two not driving full rate clock.");
	a_int_start: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> !sel_ext_ff && internal_osc_run)
		else $error("Reset did not select internal source.");

endmodule

// File: verif/ocs_osc_model.sv
// Behavioural model of an external clock source feeding the oscillator pins.
module ocs_osc_model #(
	parameter int HALF_NS = 97
) (
	input  wire logic run,
	output logic      clk_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------------
	// Source oscillation
	// ---------------------------------------------------------------
	initial clk_out = 1'b0;

	// The source stands still low while disabled, as a dead oscillator.
	// Once started it runs at a steady rate, never faster than the
	// synchroniser can follow.
	// Stable source rate.
	always
	begin
		#(HALF_NS);
		if (run)
			clk_out = ~clk_out;
		else
			clk_out = 1'b0;
	end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the oscillator clock source switch.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0]  a;
		logic [31:0] d;
		logic [1:0]  r;
		logic [31:0] q;
	} ocs_row_s;

	logic               aclk;
	logic               aresetn;
	logic [7:0]         awaddr;
	logic               awvalid;
	logic               awready;
	logic [31:0]        wdata;
	logic [3:0]         wstrb;
	logic               wvalid;
	logic               wready;
	logic [1:0]         bresp;
	logic               bvalid;
	logic               bready;
	logic [7:0]         araddr;
	logic               arvalid;
	logic               arready;
	logic [31:0]        rdata;
	logic [1:0]         rresp;
	logic               rvalid;
	logic               rready;
	logic               run_ext;
	logic               ext_clk;
	logic               rc_clk;
	logic               xtal_clk;
	logic               pin2_level;
	logic               stop_mode;
	ocs_pkg::ocs_pad_s  porta_pad;
	ocs_pkg::ocs_pad_s  out_pad;
	logic               porta_in;
	ocs_pkg::ocs_pin1_e role;
	logic               full_clk;
	logic               half_clk;
	logic               int_run;
	logic               engaged;
	logic [31:0]        d;
	logic [1:0]         r;
	int                 n;
	int                 failures;
	int                 checks_done;

	localparam ocs_row_s rows [7] = '{
		'{ocs_pkg::OFS_TRIM, 32'h0000_005a, ocs_pkg::RESP_OKAY, 32'h0000_005a},
		'{ocs_pkg::OFS_TRIM, 32'h0000_01a5, ocs_pkg::RESP_OKAY, 32'h0000_00a5},
		'{8'h10, 32'h0000_00ff, ocs_pkg::RESP_SLVERR, 32'h0000_0000},
		'{ocs_pkg::OFS_PULLUP, 32'h0000_0001, ocs_pkg::RESP_OKAY, 32'h0000_0001},
		'{ocs_pkg::OFS_STATUS, 32'h0000_0002, ocs_pkg::RESP_OKAY, 32'h0000_0000},
		'{ocs_pkg::OFS_CONFIG, 32'h0000_0002, ocs_pkg::RESP_OKAY, 32'h0000_0002},
		'{ocs_pkg::OFS_TRIM, 32'h0000_0077, ocs_pkg::RESP_OKAY, 32'h0000_0077}
	};

	// ---------------------------------------------------------------
	// Clock, partner sources and pin two wire
	// ---------------------------------------------------------------
	initial aclk = 1'b0;
	always #10 aclk = ~aclk;

	// Pin two floats high through the port pull-up when nobody drives.
	assign pin2_level = out_pad.oe ? out_pad.o : 1'b1;

	ocs_osc_model #(.HALF_NS(97))  u_ext (.run(run_ext), .clk_out(ext_clk));
	ocs_osc_model #(.HALF_NS(113)) u_rc (.run(1'b1), .clk_out(rc_clk));
	ocs_osc_model #(.HALF_NS(131)) u_xtal (.run(1'b1), .clk_out(xtal_clk));

	ocs_clock_switch DUT (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.osc_in_pin(ext_clk), .osc_out_pin_in(pin2_level),
		.rc_osc_clock(rc_clk), .crystal_osc_clock(xtal_clk),
		.stop_mode(stop_mode), .porta_bit4_pad(porta_pad),
		.osc_out_pad(out_pad), .porta_bit4_in(porta_in),
		.osc_in_role(role), .full_rate_clock(full_clk),
		.half_rate_clock(half_clk), .internal_osc_run(int_run),
		.ext_clock_engaged(engaged)
	);

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
		begin
			$display("TEST PASSED");
		end
		else
		begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic give_up();
		failures++;
		finish_test();
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	// Ready is sampled in the settled low phase; payload moves at the edge.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] resp);
		int   k;
		logic aw_ok;
		logic w_ok;
		logic got;
		k = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			aw_ok = awvalid && awready;
			w_ok = wvalid && wready;
			got = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (aw_ok)
				awvalid <= 1'b0;
			if (w_ok)
				wvalid <= 1'b0;
			k++;
		end while (!got && k < 50);
		if (!got)
			give_up();
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] resp);
		int   k;
		logic ar_ok;
		logic got;
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ar_ok = arvalid && arready;
			got = rvalid;
			v = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar_ok)
				arvalid <= 1'b0;
			k++;
		end while (!got && k < 50);
		if (!got)
			give_up();
	endtask

	// Cycles between two rising edges of the full or half rate clock.
	task automatic measure(input logic pick_half, output int cyc);
		int   k;
		int   rises;
		logic prev;
		logic cur;
		k = 0;
		rises = 0;
		cyc = 0;
		prev = 1'b1;
		while (rises < 2 && k < 1000)
		begin
			@(negedge aclk);
			cur = pick_half ? half_clk : full_clk;
			if (cur === 1'b1 && prev === 1'b0)
				rises++;
			if (rises == 1)
				cyc++;
			prev = cur;
			k++;
		end
		// Return on a rising edge so the caller drives off the sampling edge.
		@(posedge aclk);
		if (rises < 2)
			give_up();
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		{aresetn, awaddr, awvalid, wdata, wstrb, wvalid} = '0;
		{araddr, arvalid, run_ext, stop_mode} = '0;
		// Response ready stands high all run, so no call lowers it.
		bready = 1'b1;
		rready = 1'b1;
		porta_pad = '{o: 1'b0, oe: 1'b0};
		failures = 0;
		checks_done = 0;
		do_reset();
		axi_read(ocs_pkg::OFS_TRIM, d, r);
		check(d, 32'h0000_0080);
		axi_read(ocs_pkg::OFS_STATUS, d, r);
		check(d, 32'h0000_0000);
		check(32'(int_run), 32'h1);
		check(32'(role), 32'(ocs_pkg::PIN1_RELEASED));
		// Row 3 checks unmapped access; rows 5 and 7 the status and trim copy.
		foreach (rows[i])
		begin
			axi_write(rows[i].a, rows[i].d, r);
			check(32'(r), 32'(rows[i].r));
			axi_read(rows[i].a, d, r);
			check(d, rows[i].q);
			check(32'(r), 32'(rows[i].r));
		end
		// Set the port bit 4 pad high before the mode sweep; external mode passes it to pin two.
		porta_pad <= '{o: 1'b1, oe: 1'b1};
		repeat (4) @(posedge aclk);
		porta_pad <= '{o: 1'b1, oe: 1'b0};
		for (int m = 0; m < 4; m++)
		begin
			axi_write(ocs_pkg::OFS_CONFIG, 32'(m), r);
			repeat (2) @(posedge aclk);
			check(32'(role), 32'(m));
			check(32'(out_pad.oe), 32'(m != 1));
			if (m % 2 == 1)
				check(32'(out_pad.o), 32'h1);
		end
		axi_write(ocs_pkg::OFS_PULLUP, 32'h0, r);
		axi_write(ocs_pkg::OFS_CONFIG, 32'h0, r);
		repeat (2) @(posedge aclk);
		check(32'(out_pad.oe), 32'h0);
		axi_write(ocs_pkg::OFS_TRIM, 32'h1, r);
		measure(1'b0, n);
		measure(1'b0, n);
		check(32'(n), 32'd6);
		check(32'(porta_in), 32'h1);
		measure(1'b1, n);
		check(32'(n), 32'd12);
		axi_write(ocs_pkg::OFS_TRIM, 32'h3, r);
		measure(1'b0, n);
		measure(1'b0, n);
		check(32'(n), 32'd10);
		stop_mode <= 1'b1;
		repeat (3) @(posedge aclk);
		n = 0;
		repeat (40)
		begin
			@(negedge aclk);
			if (full_clk !== 1'b0)
				n++;
		end
		check(32'(n), 32'd0);
		@(posedge aclk);
		stop_mode <= 1'b0;
		// Request with the external source dead: the switch must wait.
		axi_write(ocs_pkg::OFS_CONFIG, 32'h1, r);
		axi_write(ocs_pkg::OFS_STATUS, 32'h1, r);
		repeat (60) @(posedge aclk);
		check(32'(engaged), 32'h0);
		measure(1'b0, n);
		measure(1'b0, n);
		check(32'(n), 32'd10);
		run_ext <= 1'b1;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end while (engaged !== 1'b1 && n < 3000);
		if (n >= 3000)
			give_up();
		check(32'(int_run), 32'h1);
		@(negedge aclk);
		check(32'(int_run), 32'h0);
		@(posedge aclk);
		axi_read(ocs_pkg::OFS_STATUS, d, r);
		check(d, 32'h0000_0003);
		// A 194 ns source gives nine or ten cycles; a runt would be shorter.
		measure(1'b0, n);
		check(32'(n == 9 || n == 10), 32'h1);
		run_ext <= 1'b0;
		repeat (200) @(posedge aclk);
		check(32'({engaged, int_run}), 32'h2);
		do_reset();
		@(negedge aclk);
		check(32'({engaged, int_run}), 32'h1);
		@(posedge aclk);
		axi_read(ocs_pkg::OFS_TRIM, d, r);
		check(d, 32'h0000_0080);
		axi_read(ocs_pkg::OFS_STATUS, d, r);
		check(d, 32'h0000_0000);
		finish_test();
	end
endmodule
